// [core/aid_consts.svh]
// Register offsets, field positions and timing constants of the input register decoder
`ifndef AID_CONSTS_SVH
`define AID_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AID_REG_MAIN_CMD 16'h0001
`define AID_REG_AUX_CMD 16'h0002
`define AID_REG_SPEED 16'h0003
`define AID_REG_EXT_CTRL 16'h0008
`define AID_REG_EXT_ADDR 16'h0009
`define AID_REG_EXT_VALUE 16'h0010

// ----------------------------------------
// Main command word fields
// ----------------------------------------
`define AID_MC_HALT 2
`define AID_MC_POS_OFF 6
`define AID_MC_WDOG 7
`define AID_MC_SH_OPEN 8
`define AID_MC_SH_CLOSE 9
`define AID_MC_LOCK_OPEN 10
`define AID_MC_LOCK_CLOSE 11
`define AID_MC_LOCK_OFF 12
`define AID_MC_SITE_LOCK 13
`define AID_MC_FAILSAFE 14
`define AID_MC_IGNORE_BIN 15

// ----------------------------------------
// Second command word fields
// ----------------------------------------
`define AID_AC_BUS_LSB 0
`define AID_AC_BUS_MSB 7
`define AID_AC_IPOS_GO 8
`define AID_AC_IPOS_B9 9
`define AID_AC_IPOS_B10 10
`define AID_AC_IPOS_B11 11
`define AID_AC_PST 12
`define AID_AC_IPOS_B13 13
`define AID_IPOS_BAD 4'h8
`define AID_IPOS_LOW_LAST 4'h7

// ----------------------------------------
// Speed set point and extended control fields
// ----------------------------------------
`define AID_SP_PCT_MSB 6
`define AID_SP_DIR_OPEN 7
`define AID_XC_EXEC 0
`define AID_XC_WRITE 14
`define AID_XC_READ 15

// ----------------------------------------
// Timing
// ----------------------------------------
`define AID_MCLK_HZ 40000000
`define AID_WDOG_TIMEOUT_MS 1000
`define AID_WDOG_CYCLES (`AID_WDOG_TIMEOUT_MS * (`AID_MCLK_HZ / 1000))

`endif

// [core/aid_pkg.sv]
// Types shared by the input register decoder
package aid_pkg;

    // ----------------------------------------
    // Register access request and answer
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] data;
    } aid_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } aid_reg_rsp_t;

    // ----------------------------------------
    // Drive commands toward the actuator core
    // ----------------------------------------
    typedef struct packed {
        logic positioner_off;
        logic halt;
        logic self_hold_open;
        logic self_hold_close;
        logic lock_open;
        logic lock_close;
        logic site_lockout;
        logic failsafe_trigger;
        logic ignore_binary_inputs;
        logic wdog_error;
        logic [7:0] bus_bits;
        logic ipos_valid;
        logic [3:0] ipos_number;
        logic ipos_go;
        logic partial_stroke_test;
        logic [6:0] speed_pct;
        logic speed_open;
        logic ext_done;
    } aid_drive_t;

    // ----------------------------------------
    // Pins from the actuator: power, off, far, site
    // ----------------------------------------
    typedef struct packed {
        logic power_ok;
        logic mode_off;
        logic mode_far;
        logic mode_site;
    } aid_pins_t;

    typedef enum logic [2:0] {
        AID_EXT_IDLE = 3'b001,
        AID_EXT_READ = 3'b010,
        AID_EXT_WRITE = 3'b100
    } aid_ext_state_t;

    typedef struct packed {
        aid_pins_t sync1;
        aid_pins_t sync2;
        aid_pins_t sync3;
        aid_pins_t pins;
        logic [15:0] main_cmd;
        logic [15:0] aux_cmd;
        logic [15:0] speed;
        logic [15:0] ext_ctrl;
        logic [15:0] ext_addr;
        logic [15:0] ext_value;
        logic last_wdog;
        logic [31:0] wdog_count;
        aid_ext_state_t ext_state;
        aid_reg_rsp_t rsp;
        aid_drive_t drv;
    } aid_state_t;

endpackage : aid_pkg

// [core/aid_ext_mem.sv]
// Extended register store with registered read data
`timescale 1ns/1ps
module aid_ext_mem #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    // Clock
    input wire logic mclk,
    // Access
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // No reset: contents are undefined until written
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : aid_ext_mem

// [core/aid_input_decoder.sv]
// Master-to-actuator input register decoder
// Operation
// - Command bit 6 in far-control mode switches the positioner off.
// - Watchdog bit 7 must toggle within the time-out, else an error flags.
// - Far-control bits 8 and 9 start held open/close moves until a halt.
// - Bit 10 latches top-priority open; cleared by bit 12, power loss, off.
// - Bit 11 latches top-priority close; cleared by bit 12, power loss, off.
// - Bit 13 blocks local selector operation in site mode.
// - Bit 14 triggers the fail-safe unit only when one is fitted.
// - Bit 15 stops binary input processing.
// - Second command bits 0 to 7 are freely mappable bus bits.
// - Bits 13,11,10,9 select intermediate position; code 8 unassigned.
// - Speed register bits 0-6 give percent, bit 7 selects open direction.
// - Extended control bit 15 reads, bit 14 writes, bit 0 executes.
// - Register 9 holds the extended register address, 0 to 65535.
// - Register 10 hex holds the value for an extended write.
// - Extended registers give further commands and extra read-out.
// - Registers accept single and multiple writes and read back.
// - Bit 2 halts in far-control mode and cancels held moves.
`timescale 1ns/1ps
`include "aid_consts.svh"
module aid_input_decoder
    import aid_pkg::*;
#(
    parameter int WDOG_CYCLES = `AID_WDOG_CYCLES,
    parameter bit FAILSAFE_FITTED = 1'b1,
    parameter int EXT_ADDR_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register access from the fieldbus
    input wire aid_reg_req_t reg_req,
    output aid_reg_rsp_t reg_rsp,
    // Actuator pins
    input wire aid_pins_t pins_async,
    // Drive commands
    output aid_drive_t drive
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // A pin change counts once stages two and three agree
    function automatic aid_pins_t aid_settle(input aid_pins_t held, input aid_pins_t s2, input aid_pins_t s3);
        aid_settle = aid_pins_t'((s2 & ~(s2 ^ s3)) | (held & (s2 ^ s3)));
    endfunction : aid_settle

    // Intermediate position number 1..15 from the raw code
    function automatic logic [3:0] aid_ipos_num(input logic [3:0] code);
        if (code <= `AID_IPOS_LOW_LAST) begin
            aid_ipos_num = code + 4'h1;
        end else begin
            aid_ipos_num = code;
        end
    endfunction : aid_ipos_num

    // ----------------------------------------
    // State
    // ----------------------------------------
    aid_state_t st;
    aid_state_t next_st;
    logic mem_we;
    logic [15:0] mem_rdata;
    logic [3:0] ipos_code;
    logic far;
    logic site;
    logic halt_req;
    logic [15:0] mc;
    logic [15:0] ac;

    aid_ext_mem #(
        .ADDR_W(EXT_ADDR_W),
        .DATA_W(16)
    ) u_ext_mem (
        .mclk(mclk),
        .we(mem_we),
        .addr(st.ext_addr[EXT_ADDR_W-1:0]),
        .wdata(st.ext_value),
        .rdata(mem_rdata)
    );

    assign reg_rsp = st.rsp;
    assign drive = st.drv;

    always_comb begin
        next_st = st;
        mem_we = 1'b0;

        // ----------------------------------------
        // Pin synchronisers
        // ----------------------------------------
        next_st.sync1 = pins_async;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.pins = aid_settle(st.pins, st.sync2, st.sync3);
        far = st.pins.mode_far & ~st.pins.mode_off;
        site = st.pins.mode_site & ~st.pins.mode_off;

        // ----------------------------------------
        // Register writes and read-back
        // ----------------------------------------
        next_st.rsp.valid = 1'b0;
        next_st.drv.ipos_go = 1'b0;
        next_st.drv.partial_stroke_test = 1'b0;
        next_st.drv.ext_done = 1'b0;
        if (reg_req.wr) begin
            case (reg_req.addr)
                `AID_REG_MAIN_CMD: begin
                    next_st.main_cmd = reg_req.data;
                end
                `AID_REG_AUX_CMD: begin
                    next_st.aux_cmd = reg_req.data;
                    if (reg_req.data[`AID_AC_PST] && !st.aux_cmd[`AID_AC_PST]) begin
                        next_st.drv.partial_stroke_test = 1'b1;
                    end
                end
                `AID_REG_SPEED: begin
                    next_st.speed = reg_req.data;
                end
                `AID_REG_EXT_CTRL: begin
                    next_st.ext_ctrl = reg_req.data;
                end
                `AID_REG_EXT_ADDR: begin
                    next_st.ext_addr = reg_req.data;
                end
                `AID_REG_EXT_VALUE: begin
                    next_st.ext_value = reg_req.data;
                end
                default: begin
                end
            endcase
        end
        if (reg_req.rd) begin
            next_st.rsp.valid = 1'b1;
            case (reg_req.addr)
                `AID_REG_MAIN_CMD: next_st.rsp.data = st.main_cmd;
                `AID_REG_AUX_CMD: next_st.rsp.data = st.aux_cmd;
                `AID_REG_SPEED: next_st.rsp.data = st.speed;
                `AID_REG_EXT_CTRL: next_st.rsp.data = st.ext_ctrl;
                `AID_REG_EXT_ADDR: next_st.rsp.data = st.ext_addr;
                `AID_REG_EXT_VALUE: next_st.rsp.data = st.ext_value;
                default: next_st.rsp.data = 16'h0000;
            endcase
        end

        // Decode from the stored words, one cycle after the write
        mc = st.main_cmd;
        ac = st.aux_cmd;

        // ----------------------------------------
        // Main command word
        // ----------------------------------------
        // Positioner off in far mode
        next_st.drv.positioner_off = mc[`AID_MC_POS_OFF] & far;
        halt_req = mc[`AID_MC_HALT] & far;
        next_st.drv.halt = halt_req;
        // Held moves, start wins over halt
        if (!far) begin
            next_st.drv.self_hold_open = 1'b0;
            next_st.drv.self_hold_close = 1'b0;
        end else begin
            if (halt_req) begin
                next_st.drv.self_hold_open = 1'b0;
                next_st.drv.self_hold_close = 1'b0;
            end
            if (mc[`AID_MC_SH_OPEN]) begin
                next_st.drv.self_hold_open = 1'b1;
            end
            if (mc[`AID_MC_SH_CLOSE]) begin
                next_st.drv.self_hold_close = 1'b1;
            end
        end
        // Open lock: end position does not clear it
        if (mc[`AID_MC_LOCK_OFF]) begin
            next_st.drv.lock_open = 1'b0;
            next_st.drv.lock_close = 1'b0;
        end
        if (mc[`AID_MC_LOCK_OPEN] && (far || site)) begin
            next_st.drv.lock_open = 1'b1;
        end
        // Close lock: end position does not clear it
        if (mc[`AID_MC_LOCK_CLOSE] && (far || site)) begin
            next_st.drv.lock_close = 1'b1;
        end
        // Power loss or off mode always wins
        if (!st.pins.power_ok || st.pins.mode_off) begin
            next_st.drv.lock_open = 1'b0;
            next_st.drv.lock_close = 1'b0;
        end
        next_st.drv.site_lockout = mc[`AID_MC_SITE_LOCK];
        // Only with a fail-safe unit fitted
        next_st.drv.failsafe_trigger = mc[`AID_MC_FAILSAFE] & FAILSAFE_FITTED;
        next_st.drv.ignore_binary_inputs = mc[`AID_MC_IGNORE_BIN];

        // ----------------------------------------
        // Bus watchdog
        // ----------------------------------------
        next_st.last_wdog = mc[`AID_MC_WDOG];
        // Toggle restarts the time-out and clears the error
        if (mc[`AID_MC_WDOG] != st.last_wdog) begin
            next_st.wdog_count = 32'h0000_0000;
            next_st.drv.wdog_error = 1'b0;
        end else if (st.wdog_count >= 32'(WDOG_CYCLES - 1)) begin
            next_st.drv.wdog_error = 1'b1;
        end else begin
            next_st.wdog_count = st.wdog_count + 32'h0000_0001;
        end

        // ----------------------------------------
        // Second command word and speed
        // ----------------------------------------
        // Bus bits passed to the output map
        next_st.drv.bus_bits = ac[`AID_AC_BUS_MSB:`AID_AC_BUS_LSB];
        // Position code, bit 13 as MSB
        ipos_code = {ac[`AID_AC_IPOS_B13], ac[`AID_AC_IPOS_B11], ac[`AID_AC_IPOS_B10], ac[`AID_AC_IPOS_B9]};
        next_st.drv.ipos_number = aid_ipos_num(ipos_code);
        next_st.drv.ipos_valid = (ipos_code != `AID_IPOS_BAD);
        if (reg_req.wr && reg_req.addr == `AID_REG_AUX_CMD && reg_req.data[`AID_AC_IPOS_GO]) begin
            // No move on the invalid code
            next_st.drv.ipos_go = ({reg_req.data[`AID_AC_IPOS_B13], reg_req.data[`AID_AC_IPOS_B11],
                                    reg_req.data[`AID_AC_IPOS_B10], reg_req.data[`AID_AC_IPOS_B9]}
                                   != `AID_IPOS_BAD);
        end
        // Bits 8 to 15 never decoded
        next_st.drv.speed_pct = st.speed[`AID_SP_PCT_MSB:0];
        next_st.drv.speed_open = st.speed[`AID_SP_DIR_OPEN];

        // ----------------------------------------
        // Extended register access
        // ----------------------------------------
        // Exec is taken once the command sits in the register
        case (st.ext_state)
            AID_EXT_IDLE: begin
                if (st.ext_ctrl[`AID_XC_EXEC]) begin
                    if (st.ext_ctrl[`AID_XC_READ] && !st.ext_ctrl[`AID_XC_WRITE]) begin
                        next_st.ext_state = AID_EXT_READ;
                    end else if (st.ext_ctrl[`AID_XC_WRITE] && !st.ext_ctrl[`AID_XC_READ]) begin
                        next_st.ext_state = AID_EXT_WRITE;
                    end else begin
                        // Ambiguous request is dropped, not guessed
                        next_st.ext_ctrl[`AID_XC_EXEC] = 1'b0;
                        next_st.drv.ext_done = 1'b1;
                    end
                end
            end
            AID_EXT_READ: begin
                // Read-out lands in the value register
                next_st.ext_value = mem_rdata;
                next_st.ext_ctrl[`AID_XC_EXEC] = 1'b0;
                next_st.drv.ext_done = 1'b1;
                next_st.ext_state = AID_EXT_IDLE;
            end
            AID_EXT_WRITE: begin
                mem_we = 1'b1;
                next_st.ext_ctrl[`AID_XC_EXEC] = 1'b0;
                next_st.drv.ext_done = 1'b1;
                next_st.ext_state = AID_EXT_IDLE;
            end
            default: begin
                next_st.ext_state = AID_EXT_IDLE;
            end
        endcase
        // A new write to the control word in the finishing cycle wins
        if (reg_req.wr && reg_req.addr == `AID_REG_EXT_CTRL) begin
            next_st.ext_ctrl = reg_req.data;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{ext_state: AID_EXT_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

endmodule : aid_input_decoder

// [tb/aid_master_model.sv]
// Fieldbus master model driving the register port
`timescale 1ns/1ps
module aid_master_model
    import aid_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Register access
    output aid_reg_req_t reg_req,
    input wire aid_reg_rsp_t reg_rsp
);
    logic wd_bit;
    initial begin
        reg_req = '0;
        wd_bit = 1'b0;
    end
    // One strobe per word, released a whole cycle later
    task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge mclk);
        reg_req.wr = 1'b0;
    endtask : write_reg
    task automatic write_main(input logic [15:0] d);
        wd_bit = !wd_bit;
        write_reg(16'h0001, {d[15:8], wd_bit, d[6:0]});
    endtask : write_main
    task automatic write_speed(input logic [7:0] d);
        write_reg(16'h0003, {8'h00, d});
    endtask : write_speed
    task automatic write_ctrl(input logic r, input logic w);
        write_reg(16'h0008, {r, w, 13'h0000, 1'b1});
    endtask : write_ctrl
    task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
        int i;
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
        @(negedge mclk);
        reg_req.rd = 1'b0;
        for (i = 0; i < 4 && reg_rsp.valid !== 1'b1; i++) @(negedge mclk);
        if (reg_rsp.valid !== 1'b1) begin
            aid_input_decoder_test.n_mismatch++;
            aid_input_decoder_test.complete_run();
        end else begin
            d = reg_rsp.data;
        end
    endtask : read_reg
endmodule : aid_master_model

// [tb/aid_input_decoder_monitor.sv]
// Port checker for the input register decoder
`timescale 1ns/1ps
module aid_input_decoder_monitor
    import aid_pkg::*;
#(
    parameter int WDOG_CYCLES = 20
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register access
    input wire aid_reg_req_t reg_req,
    input wire aid_reg_rsp_t reg_rsp,
    // Pins and drive
    input wire aid_pins_t pins_async,
    input wire aid_drive_t drive
);
    logic w1;
    logic w2;
    logic last_b7;
    logic [31:0] since;
    logic [3:0] code;
    assign w1 = reg_req.wr && reg_req.addr == 16'h0001;
    assign w2 = reg_req.wr && reg_req.addr == 16'h0002;
    assign code = {reg_req.data[13], reg_req.data[11:9]};
    // Saturates so a long idle never wraps back to zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            last_b7 <= 1'b0;
            since <= 32'h0;
        end else begin
            last_b7 <= w1 ? reg_req.data[7] : last_b7;
            since <= (w1 && reg_req.data[7] != last_b7) ? 32'h0 : since + 32'(since != 32'hffffffff);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_down;
        (!pins_async.power_ok || pins_async.mode_off) [*6];
    endsequence
    sequence s_go;
        ##[1:2] drive.ipos_go;
    endsequence
    rd_answer_a: assert property (reg_req.rd |=> reg_rsp.valid)
        else $error("read not answered");
    answer_cause_a: assert property (reg_rsp.valid |-> $past(reg_req.rd))
        else $error("answer without read");
    speed_decode_a: assert property (reg_req.wr && reg_req.addr == 16'h0003 |-> ##2
        drive.speed_pct == $past(reg_req.data[6:0], 2) && drive.speed_open == $past(reg_req.data[7], 2))
        else $error("speed field wrong");
    bus_bits_a: assert property (w2 |-> ##2 drive.bus_bits == $past(reg_req.data[7:0], 2))
        else $error("bus bits wrong");
    ipos_go_a: assert property (w2 && reg_req.data[8] && code != 4'h8 |-> s_go)
        else $error("move not started");
    ipos_bad_a: assert property (w2 && reg_req.data[8] && code == 4'h8 |=> !drive.ipos_go [*2])
        else $error("code 8 started a move");
    lock_clear_a: assert property (s_down |-> !drive.lock_open && !drive.lock_close)
        else $error("lock kept without power");
    halt_cancel_a: assert property (w1 && reg_req.data[2] && reg_req.data[9:8] == 2'b00 |-> ##2
        !drive.self_hold_open && !drive.self_hold_close)
        else $error("held move not halted");
    wdog_quiet_a: assert property (since > 4 && since + 4 < WDOG_CYCLES |-> !drive.wdog_error)
        else $error("early watchdog error");
    wdog_fire_a: assert property (since == WDOG_CYCLES + 4 |-> drive.wdog_error)
        else $error("watchdog error missing");
    pst_pulse_a: assert property (drive.partial_stroke_test |=> !drive.partial_stroke_test)
        else $error("stroke test not a pulse");
    ext_done_a: assert property (reg_req.wr && reg_req.addr == 16'h0008 && reg_req.data[0] |->
        ##[1:4] drive.ext_done)
        else $error("extended access not done");
endmodule : aid_input_decoder_monitor
bind aid_input_decoder aid_input_decoder_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) u_mon (.mclk(mclk),
    .reset_n(reset_n), .reg_req(reg_req), .reg_rsp(reg_rsp), .pins_async(pins_async), .drive(drive));

// [tb/aid_input_decoder_test.sv]
// Self-checking bench for the input register decoder
`timescale 1ns/1ps
module aid_input_decoder_test;
    import aid_pkg::*;
    localparam int WD = 20;
    logic mclk;
    logic reset_n;
    aid_reg_req_t reg_req;
    aid_reg_rsp_t reg_rsp;
    aid_pins_t pins_async;
    aid_drive_t drive;
    int n_mismatch;
    int total_checks;
    int n_go;
    int n_pst;
    int n_done;
    logic [15:0] v;
    logic [2:0] upper_bits;
    assign upper_bits = {drive.site_lockout, drive.failsafe_trigger, drive.ignore_binary_inputs};
    aid_master_model u_master (.mclk(mclk), .reg_req(reg_req), .reg_rsp(reg_rsp));
    aid_input_decoder #(.WDOG_CYCLES(WD), .FAILSAFE_FITTED(1'b1), .EXT_ADDR_W(16)) DUT (.mclk(mclk),
        .reset_n(reset_n), .reg_req(reg_req), .reg_rsp(reg_rsp), .pins_async(pins_async), .drive(drive));
    always #12.5 mclk = ~mclk;
    // Pulses are counted so a check never races the edge
    always @(posedge mclk) begin
        n_go += int'(drive.ipos_go === 1'b1);
        n_pst += int'(drive.partial_stroke_test === 1'b1);
        n_done += int'(drive.ext_done === 1'b1);
    end
    // ----
    // Helpers
    // ----
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle
    // Synchroniser needs four edges to settle the pins, the drive outputs follow on the fifth
    task automatic set_pins(input logic ok, input logic off, input logic far, input logic site);
        @(negedge mclk);
        pins_async = '{power_ok: ok, mode_off: off, mode_far: far, mode_site: site};
        idle(6);
    endtask : set_pins
    task automatic main_wr(input logic [15:0] d);
        u_master.write_main(d);
        idle(2);
    endtask : main_wr
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // ----
    // Scenarios
    // ----
    task automatic t_readback();
        logic [15:0] ra [6];
        logic [15:0] ex [6];
        ra = '{16'h0002, 16'h0003, 16'h0009, 16'h0010, 16'h0005, 16'h0000};
        ex = '{16'h00a5, 16'h00e4, 16'h1234, 16'h5678, 16'h0000, 16'h0000};
        for (int k = 0; k < 5; k++) u_master.write_reg(ra[k], k == 1 ? 16'h00e4 : (k == 4 ? 16'hffff : ex[k]));
        idle(2);
        chk("speed pct", 16'd100, drive.speed_pct);
        chk("speed open", 16'h1, drive.speed_open);
        chk("bus bits", 16'h00a5, drive.bus_bits);
        for (int k = 0; k < 6; k++) begin
            u_master.read_reg(ra[k], v);
            chk("readback", ex[k], v);
        end
    endtask : t_readback
    task automatic t_far();
        set_pins(1'b1, 1'b0, 1'b1, 1'b0);
        main_wr(16'h0040);
        chk("positioner off", 16'h1, drive.positioner_off);
        for (int k = 0; k < 2; k++) begin
            main_wr(16'h0100 << k);
            main_wr(16'h0000);
            chk("held move", 16'h1 << k, {drive.self_hold_close, drive.self_hold_open});
            main_wr(16'h0004);
            chk("halted move", 16'h0, {drive.self_hold_close, drive.self_hold_open});
            chk("halt", 16'h1, drive.halt);
        end
        main_wr(16'he000);
        chk("upper bits", 16'h7, upper_bits);
        main_wr(16'h0000);
        chk("upper clear", 16'h0, upper_bits);
    endtask : t_far
    task automatic t_wdog();
        main_wr(16'h0000);
        chk("wdog fresh", 16'h0, drive.wdog_error);
        idle(WD + 4);
        chk("wdog expired", 16'h1, drive.wdog_error);
        main_wr(16'h0000);
        idle(1);
        chk("wdog toggled", 16'h0, drive.wdog_error);
    endtask : t_wdog
    task automatic t_lock();
        set_pins(1'b1, 1'b0, 1'b0, 1'b1);
        main_wr(16'h0400);
        main_wr(16'h0000);
        chk("lock open held", 16'h1, drive.lock_open);
        main_wr(16'h1000);
        chk("lock off", 16'h0, drive.lock_open);
        main_wr(16'h0800);
        chk("lock close", 16'h1, drive.lock_close);
        set_pins(1'b0, 1'b0, 1'b0, 1'b0);
        chk("lock power loss", 16'h0, drive.lock_close);
        set_pins(1'b1, 1'b0, 1'b1, 1'b0);
        main_wr(16'h0400);
        chk("lock far", 16'h1, drive.lock_open);
        set_pins(1'b1, 1'b1, 1'b0, 1'b0);
        chk("lock off mode", 16'h0, drive.lock_open);
        set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    endtask : t_lock
    task automatic t_ipos();
        logic [3:0] c;
        int g;
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            g = n_go;
            u_master.write_reg(16'h0002, {2'b11, c[3], 1'b0, c[2:0], 1'b1, 4'h0, c});
            idle(2);
            chk("ipos go", 16'(c != 4'h8), 16'(n_go - g));
            chk("ipos valid", 16'(c != 4'h8), drive.ipos_valid);
            if (c != 4'h8) chk("ipos number", c < 4'h8 ? c + 4'h1 : c, drive.ipos_number);
            chk("bus bits", {12'h000, c}, drive.bus_bits);
        end
        g = n_pst;
        u_master.write_reg(16'h0002, 16'h1000);
        u_master.write_reg(16'h0002, 16'h1000);
        idle(2);
        chk("stroke test", 16'h1, 16'(n_pst - g));
    endtask : t_ipos
    task automatic t_ext();
        int g;
        u_master.write_reg(16'h0009, 16'hfff3);
        u_master.write_reg(16'h0010, 16'hbeef);
        g = n_done;
        u_master.write_ctrl(1'b0, 1'b1);
        idle(4);
        chk("ext done", 16'h1, 16'(n_done - g));
        u_master.read_reg(16'h0008, v);
        chk("exec cleared", 16'h4000, v);
        u_master.write_reg(16'h0009, 16'h0001);
        u_master.write_reg(16'h0010, 16'h1111);
        u_master.write_ctrl(1'b0, 1'b1);
        idle(4);
        u_master.write_reg(16'h0009, 16'hfff3);
        u_master.write_reg(16'h0010, 16'h0000);
        u_master.write_ctrl(1'b1, 1'b0);
        idle(4);
        u_master.read_reg(16'h0010, v);
        chk("ext read", 16'hbeef, v);
        g = n_done;
        u_master.write_reg(16'h0010, 16'h2222);
        u_master.write_ctrl(1'b1, 1'b1);
        idle(4);
        u_master.read_reg(16'h0010, v);
        chk("both ops value", 16'h2222, v);
        chk("both ops done", 16'h1, 16'(n_done - g));
    endtask : t_ext
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        pins_async = '{power_ok: 1'b1, mode_off: 1'b0, mode_far: 1'b1, mode_site: 1'b0};
        n_mismatch = 0;
        total_checks = 0;
        n_go = 0;
        n_pst = 0;
        n_done = 0;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        idle(6);
        t_readback();
        t_far();
        t_wdog();
        t_lock();
        t_ipos();
        t_ext();
        complete_run();
    end
endmodule : aid_input_decoder_test
